/* src/psb_regs.sv */
// Status, shutdown cause and step-down regulator control registers behind the serial control register port.
// ============================================================================
// Notes on behaviour
// (R1) Eight-bit read-only status register, zero after reset, only bit 0 meaningful.
// (R2) Status bit 0 follows whether die temperature is above the hot threshold.
// (R3) Shutdown cause register resets to zero; bits 7 to 4 reserved, 3 to 0 flags.
// (R4) Cause flags set by device, held until host writes one to clear.
// (R5) Undervoltage shutdown sets bit 2 and the shutdown summary interrupt.
// (R6) Unmasked power fault shutdown sets bit 1 and the summary interrupt.
// (R7) Power fault source is recorded outside this slice for the host to read.
// (R8) Critical temperature shutdown sets bit 0 and the summary interrupt.
// (R9) Cold off flag clears by writing one but is never set, reads zero.
// (R10) Regulator one control register is read-write with a factory reset value.
// (R11) Regulator one bits 7 to 1 hold its seven-bit voltage code.
// (R12) Regulator two control register matches regulator one, own factory reset.
// (R13) Regulator two bits 7 to 1 hold its seven-bit voltage code.
// (R14) Bit 0 low: a lower code makes the output slew down actively.
// (R15) Bit 0 high: a lower code lets the output decay passively.
// (R16) Shutdown interrupt mask bit 3, reset one, suppresses the shutdown interrupt.
// (R17) Die temperature interrupt mask bit 0, reset one, suppresses that interrupt.
// (R18) Writing zero to a flag does nothing; reserved and read-only bits ignore writes.
`timescale 1ns/1ps

module psb_regs #(
  parameter logic [7:0] REG_ONE_RESET = 8'h00,
  parameter logic [7:0] REG_TWO_RESET = 8'h00
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register port from the serial control interface
  input wire psb_pkg::psb_req_t req_in,
  output logic [7:0] rdata_out,
  // Asynchronous sensor and shutdown events
  input wire logic die_hot_in,
  input wire logic critical_temp_shutdown_in,
  input wire logic power_fault_shutdown_in,
  input wire logic undervoltage_shutdown_in,
  // To the interrupt and regulator logic
  output logic shutdown_summary_interrupt_out,
  output logic die_temp_interrupt_out,
  output psb_pkg::psb_reg_ctl_t regulator_one_out,
  output psb_pkg::psb_reg_ctl_t regulator_two_out
);

  // ==========================================================================
  // Input synchronisers
  // The shutdown and temperature pins come from circuits that do not share
  // this clock, so each passes two flip-flops before any logic reads it.
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [2:0] event_prev;
  logic [3:0] next_sync_a;
  logic [3:0] next_sync_b;
  logic [2:0] next_event_prev;
  psb_pkg::psb_event_t rise;

  always_comb begin
    next_sync_a = {undervoltage_shutdown_in, power_fault_shutdown_in, critical_temp_shutdown_in, die_hot_in};
    next_sync_b = sync_a;
    next_event_prev = sync_b[3:1];
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      event_prev <= 3'h0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      event_prev <= next_event_prev;
    end
  end

  // A shutdown counts once, on the rising edge of its pin, so a pin that
  // stays high does not set a flag again after the host has cleared it.
  always_comb begin
    rise.critical_temp = sync_b[1] & ~event_prev[0];
    rise.power_fault = sync_b[2] & ~event_prev[1];
    rise.undervoltage = sync_b[3] & ~event_prev[2];
  end

  // ==========================================================================
  // Register access helpers
  function automatic logic hit(input psb_pkg::psb_req_t r, input logic [7:0] off);
    hit = r.write && (r.addr == off);
  endfunction

  function automatic logic code_lower(input logic [7:0] old_val, input logic [7:0] new_val);
    code_lower = new_val[7:psb_pkg::BIT_CODE_LSB] < old_val[7:psb_pkg::BIT_CODE_LSB];
  endfunction

  function automatic psb_pkg::psb_reg_ctl_t ctl_word(input logic [7:0] value, input logic lowered);
    ctl_word.code = value[7:psb_pkg::BIT_CODE_LSB];
    ctl_word.passive_ramp = value[psb_pkg::BIT_PASSIVE_RAMP];
    ctl_word.lower = lowered;
  endfunction

  // Regulator control words after reset, taken from the factory values.
  localparam psb_pkg::psb_reg_ctl_t ONE_CTL_RESET = '{
    code: REG_ONE_RESET[7:psb_pkg::BIT_CODE_LSB],
    passive_ramp: REG_ONE_RESET[psb_pkg::BIT_PASSIVE_RAMP],
    lower: 1'b0
  };
  localparam psb_pkg::psb_reg_ctl_t TWO_CTL_RESET = '{
    code: REG_TWO_RESET[7:psb_pkg::BIT_CODE_LSB],
    passive_ramp: REG_TWO_RESET[psb_pkg::BIT_PASSIVE_RAMP],
    lower: 1'b0
  };

  // ==========================================================================
  // Die temperature status
  // The status is not latched; the host always sees the present temperature state.
  logic die_hot_status;
  logic next_die_hot_status;

  always_comb begin
    next_die_hot_status = sync_b[0]; // [R2]
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      die_hot_status <= psb_pkg::RST_DIE_TEMP_STATUS[psb_pkg::BIT_DIE_HOT_STATUS]; // [R1]
    end else begin
      die_hot_status <= next_die_hot_status;
    end
  end

  // ==========================================================================
  // Shutdown cause flags and summary
  logic [3:0] cause;
  logic summary;
  logic [3:0] next_cause;
  logic next_summary;

  always_comb begin
    logic [3:0] set_bits;
    logic [3:0] clr_bits;
    set_bits = 4'h0;
    clr_bits = 4'h0;
    set_bits[psb_pkg::BIT_UNDERVOLTAGE] = rise.undervoltage; // [R5]
    set_bits[psb_pkg::BIT_POWER_FAULT] = rise.power_fault; // [R6]
    set_bits[psb_pkg::BIT_CRITICAL_TEMP] = rise.critical_temp; // [R8]
    // The cold off flag has no source, so it stays zero. [R9]
    set_bits[psb_pkg::BIT_COLD_OFF] = 1'b0;
    if (hit(req_in, psb_pkg::OFF_SHUTDOWN_CAUSE_FLAGS)) begin
      clr_bits = req_in.wdata[3:0]; // [R4] [R18]
    end
    // A set in the same cycle as a clear wins so no shutdown cause is lost.
    next_cause = (cause & ~clr_bits) | set_bits; // [R4]
    next_summary = summary | (|set_bits); // [R5] [R6] [R8]
    // The summary only drops once the host has cleared every cause.
    if (|clr_bits) begin
      next_summary = |next_cause;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cause <= psb_pkg::RST_SHUTDOWN_CAUSE_FLAGS[3:0]; // [R3]
      summary <= 1'b0;
    end else begin
      cause <= next_cause;
      summary <= next_summary;
    end
  end

  // ==========================================================================
  // Regulator one control
  // The lowering flag tells the regulator that this write asks it to move down.
  logic [7:0] reg_one;
  logic one_lower;
  logic [7:0] next_reg_one;
  logic next_one_lower;

  always_comb begin
    next_reg_one = reg_one;
    next_one_lower = one_lower;
    if (hit(req_in, psb_pkg::OFF_REGULATOR_ONE_CONTROL)) begin
      next_reg_one = req_in.wdata; // [R10] [R11]
      next_one_lower = code_lower(reg_one, req_in.wdata); // [R14] [R15]
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reg_one <= REG_ONE_RESET; // [R10]
      one_lower <= 1'b0;
    end else begin
      reg_one <= next_reg_one;
      one_lower <= next_one_lower;
    end
  end

  // ==========================================================================
  // Regulator two control
  // Same layout as regulator one, with its own factory value.
  logic [7:0] reg_two;
  logic two_lower;
  logic [7:0] next_reg_two;
  logic next_two_lower;

  always_comb begin
    next_reg_two = reg_two;
    next_two_lower = two_lower;
    if (hit(req_in, psb_pkg::OFF_REGULATOR_TWO_CONTROL)) begin
      next_reg_two = req_in.wdata; // [R12] [R13]
      next_two_lower = code_lower(reg_two, req_in.wdata); // [R14] [R15]
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reg_two <= REG_TWO_RESET; // [R12]
      two_lower <= 1'b0;
    end else begin
      reg_two <= next_reg_two;
      two_lower <= next_two_lower;
    end
  end

  // ==========================================================================
  // Interrupt mask
  // Only the two mask bits served by this slice are kept; the rest read zero.
  logic [7:0] irq_mask;
  logic [7:0] next_irq_mask;

  always_comb begin
    next_irq_mask = irq_mask;
    if (hit(req_in, psb_pkg::OFF_INTERRUPT_MASK)) begin
      next_irq_mask = req_in.wdata & psb_pkg::MASK_WRITABLE; // [R16] [R17] [R18]
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask <= psb_pkg::RST_INTERRUPT_MASK; // [R16] [R17]
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // ==========================================================================
  // Read data
  // Read data holds until the next read, so a slow host may fetch it late.
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = rdata_out;
    if (req_in.read) begin
      case (req_in.addr)
        psb_pkg::OFF_DIE_TEMP_STATUS: next_rdata = {7'h00, die_hot_status}; // [R1]
        psb_pkg::OFF_SHUTDOWN_CAUSE_FLAGS: next_rdata = {4'h0, cause}; // [R3]
        psb_pkg::OFF_REGULATOR_ONE_CONTROL: next_rdata = reg_one;
        psb_pkg::OFF_REGULATOR_TWO_CONTROL: next_rdata = reg_two;
        psb_pkg::OFF_INTERRUPT_MASK: next_rdata = irq_mask;
        default: next_rdata = 8'h00; // [R18]
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // ==========================================================================
  // Interrupt and regulator outputs
  // Outputs follow the next state, so they change on the same edge as the registers.
  logic next_summary_irq;
  logic next_die_irq;
  psb_pkg::psb_reg_ctl_t next_one_ctl;
  psb_pkg::psb_reg_ctl_t next_two_ctl;

  always_comb begin
    next_summary_irq = next_summary & ~next_irq_mask[psb_pkg::BIT_SHUTDOWN_MASK]; // [R16]
    next_die_irq = next_die_hot_status & ~next_irq_mask[psb_pkg::BIT_DIE_TEMP_MASK]; // [R17]
    next_one_ctl = ctl_word(next_reg_one, next_one_lower); // [R11] [R14] [R15]
    next_two_ctl = ctl_word(next_reg_two, next_two_lower); // [R13] [R14] [R15]
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      shutdown_summary_interrupt_out <= 1'b0;
      die_temp_interrupt_out <= 1'b0;
      regulator_one_out <= ONE_CTL_RESET; // [R10]
      regulator_two_out <= TWO_CTL_RESET; // [R12]
    end else begin
      shutdown_summary_interrupt_out <= next_summary_irq;
      die_temp_interrupt_out <= next_die_irq;
      regulator_one_out <= next_one_ctl;
      regulator_two_out <= next_two_ctl;
    end
  end

  // Fault source capture lives in the power fault block; only the cause flag
  // is held here. [R7]

endmodule

/* src/psb_pkg.sv */
// Package of offsets, field positions, reset values and carrier types for the status and regulator register slice.
package psb_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_DIE_TEMP_STATUS = 8'h04;
  localparam logic [7:0] OFF_SHUTDOWN_CAUSE_FLAGS = 8'h05;
  localparam logic [7:0] OFF_REGULATOR_ONE_CONTROL = 8'h20;
  localparam logic [7:0] OFF_REGULATOR_TWO_CONTROL = 8'h21;
  localparam logic [7:0] OFF_INTERRUPT_MASK = 8'h08;

  // ==========================================================================
  // Field positions
  localparam int BIT_DIE_HOT_STATUS = 0;
  localparam int BIT_CRITICAL_TEMP = 0;
  localparam int BIT_POWER_FAULT = 1;
  localparam int BIT_UNDERVOLTAGE = 2;
  localparam int BIT_COLD_OFF = 3;
  localparam int BIT_PASSIVE_RAMP = 0;
  localparam int BIT_CODE_LSB = 1;
  localparam int BIT_SHUTDOWN_MASK = 3;
  localparam int BIT_DIE_TEMP_MASK = 0;

  // ==========================================================================
  // Reset values and writable bit masks
  localparam logic [7:0] RST_DIE_TEMP_STATUS = 8'h00;
  localparam logic [7:0] RST_SHUTDOWN_CAUSE_FLAGS = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_MASK = 8'h09;
  localparam logic [3:0] CAUSE_WRITABLE = 4'h7;
  localparam logic [7:0] MASK_WRITABLE = 8'h09;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psb_req_t;

  typedef struct packed {
    logic critical_temp;
    logic power_fault;
    logic undervoltage;
  } psb_event_t;

  typedef struct packed {
    logic [6:0] code;
    logic passive_ramp;
    logic lower;
  } psb_reg_ctl_t;

endpackage

/* verification/psb_regs_properties.sv */
// Port assertions for the status and regulator register slice.
`timescale 1ns/1ps
module psb_regs_properties (
  // Clock, reset and requests
  input wire logic clock_in,
  input wire logic rst_in,
  input wire psb_pkg::psb_req_t req_in,
  // Events and outputs
  input wire logic die_hot_in,
  input wire logic critical_temp_shutdown_in,
  input wire logic power_fault_shutdown_in,
  input wire logic undervoltage_shutdown_in,
  input wire logic [7:0] rdata_out,
  input wire logic shutdown_summary_interrupt_out,
  input wire logic die_temp_interrupt_out,
  input wire psb_pkg::psb_reg_ctl_t regulator_one_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ====
  // Helpers
  logic [7:0] last_wdata;
  wire logic quiet = !critical_temp_shutdown_in && !power_fault_shutdown_in && !undervoltage_shutdown_in;
  wire logic rd_stat = req_in.read && req_in.addr == 8'h04;
  wire logic rd_none = req_in.read && !(req_in.addr inside {8'h04, 8'h05, 8'h08, 8'h20, 8'h21});
  wire logic wr_one = req_in.write && req_in.addr == 8'h20;
  always_ff @(posedge clock_in) last_wdata <= req_in.wdata;
  // ====
  // Checks
  stat_rsvd_a: assert property (rd_stat |=> rdata_out[7:1] == 7'h00)
    else $error("status upper bits set");
  die_hot_a: assert property (die_hot_in [*4] ##0 rd_stat |=> rdata_out[0])
    else $error("hot status not read");
  cause_rsvd_a: assert property (req_in.read && req_in.addr == 8'h05 |=> rdata_out[7:3] == 5'h00)
    else $error("cause upper bits set");
  unmapped_zero_a: assert property (rd_none |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  reg_field_a: assert property (wr_one |=> {regulator_one_out.code, regulator_one_out.passive_ramp} == last_wdata)
    else $error("control fields not written");
  reg_lower_a: assert property (wr_one && req_in.wdata[7:1] < regulator_one_out.code |=> regulator_one_out.lower)
    else $error("lower code not flagged");
  reset_quiet_a: assert property ($fell(rst_in) |-> rdata_out == 8'h00 && !shutdown_summary_interrupt_out)
    else $error("outputs not idle after reset");
  clear_summary_a: assert property (quiet [*4] ##0 (req_in.write && req_in.addr == 8'h05 && req_in.wdata[2:0] == 3'h7)
    |-> ##[1:3] !shutdown_summary_interrupt_out)
    else $error("summary not cleared");
  cover property (wr_one);
  cover property ($rose(shutdown_summary_interrupt_out));
  cover property ($rose(die_temp_interrupt_out));
endmodule

bind psb_regs psb_regs_properties chk (.clock_in(clock_in), .rst_in(rst_in), .req_in(req_in),
  .die_hot_in(die_hot_in), .critical_temp_shutdown_in(critical_temp_shutdown_in),
  .power_fault_shutdown_in(power_fault_shutdown_in), .undervoltage_shutdown_in(undervoltage_shutdown_in),
  .rdata_out(rdata_out), .shutdown_summary_interrupt_out(shutdown_summary_interrupt_out),
  .die_temp_interrupt_out(die_temp_interrupt_out), .regulator_one_out(regulator_one_out));

/* verification/psb_host.sv */
// Host model that issues single-byte register requests.
`timescale 1ns/1ps
module psb_host (
  // Clock and read data
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  // Requests
  output psb_pkg::psb_req_t req_out
);
  initial req_out = '0;
  // Released address and data show the inverse so a stale value cannot pass.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock_in);
    req_out = '{write: w, read: !w, addr: a, wdata: d};
    @(negedge clock_in);
    req_out = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
    @(negedge clock_in);
    q = rdata_in;
  endtask
endmodule

/* verification/psb_regs_tb.sv */
// Self-checking bench for the status and regulator register slice.
`timescale 1ns/1ps
module psb_regs_tb;
  // Factory values chosen for the bench; any byte will do.
  localparam logic [7:0] ONE_RST = 8'h5a;
  localparam logic [7:0] TWO_RST = 8'hc3;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic die_hot = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [7:0] q;
  logic [7:0] rdata;
  logic sd_int;
  logic dt_int;
  logic lo;
  psb_pkg::psb_req_t req;
  psb_pkg::psb_reg_ctl_t r1;
  psb_pkg::psb_reg_ctl_t r2;
  int num_errors = 0;
  int samples_checked = 0;
  int m_reg[2] = '{ONE_RST, TWO_RST};
  int d;
  int k;
  always #20 clock_in = ~clock_in;
  psb_regs #(.REG_ONE_RESET(ONE_RST), .REG_TWO_RESET(TWO_RST)) uut (.clock_in(clock_in), .rst_in(rst_in),
    .req_in(req), .rdata_out(rdata), .die_hot_in(die_hot),
    .critical_temp_shutdown_in(ev[0]), .power_fault_shutdown_in(ev[1]), .undervoltage_shutdown_in(ev[2]),
    .shutdown_summary_interrupt_out(sd_int), .die_temp_interrupt_out(dt_int), .regulator_one_out(r1),
    .regulator_two_out(r2));
  psb_host host (.clock_in(clock_in), .rdata_in(rdata), .req_out(req));
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    check("read", {1'b0, q}, {1'b0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.access(1'b1, a, v, q);
  endtask
  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h1d8e30bd));
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h08, 8'h09);
    rd(8'h33, 8'h00);
    rd(8'h20, ONE_RST);
    rd(8'h21, TWO_RST);
    check("ctl one", r1, {ONE_RST, 1'b0});
    check("ctl two", r2, {TWO_RST, 1'b0});
    // Random codes land on alternate regulators, so each sees raises and drops.
    for (int i = 0; i < 12; i++) begin
      k = i % 2;
      d = $urandom;
      lo = d[7:1] < m_reg[k][7:1];
      wr(8'h20 + 8'(k), d[7:0]);
      check("ctl", k ? r2 : r1, {d[7:0], lo});
      rd(8'h20 + 8'(k), d[7:0]);
      m_reg[k] = d;
    end
    wr(8'h04, 8'hff);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h00);
    die_hot = 1'b1;
    repeat (4) @(negedge clock_in);
    rd(8'h04, 8'h01);
    check("die int", {8'h00, dt_int}, 9'h001);
    die_hot = 1'b0;
    repeat (4) @(negedge clock_in);
    rd(8'h04, 8'h00);
    check("die int", {8'h00, dt_int}, 9'h000);
    for (int i = 0; i < 3; i++) begin
      ev[i] = 1'b1;
      repeat (4) @(negedge clock_in);
      ev[i] = 1'b0;
      rd(8'h05, 8'(1 << i));
      check("sd int", {8'h00, sd_int}, 9'h001);
      wr(8'h05, 8'hf8 | (8'h07 & ~8'(1 << i)));
      rd(8'h05, 8'(1 << i));
      wr(8'h05, 8'h0f);
      rd(8'h05, 8'h00);
      check("sd int", {8'h00, sd_int}, 9'h000);
    end
    // Masked again: causes and status still read, but no interrupt leaves.
    wr(8'h08, 8'h09);
    die_hot = 1'b1;
    ev[2] = 1'b1;
    repeat (4) @(negedge clock_in);
    ev[2] = 1'b0;
    rd(8'h05, 8'h04);
    check("sd int", {8'h00, sd_int}, 9'h000);
    check("die int", {8'h00, dt_int}, 9'h000);
    rd(8'h04, 8'h01);
    die_hot = 1'b0;
    // A reset in mid-run clears the pending cause and restores factory values.
    rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    rd(8'h05, 8'h00);
    rd(8'h20, ONE_RST);
    rd(8'h21, TWO_RST);
    rd(8'h08, 8'h09);
    check("sd int", {8'h00, sd_int}, 9'h000);
    end_sim();
  end
endmodule
